/* hw/adc_mode_map.vh */
`ifndef ADC_MODE_MAP_VH
`define ADC_MODE_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MODE_ADDR       4'h1
`define STAT_ADDR       4'h3

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define DLY_MSB         10
`define DLY_LSB         8
`define MODE_MSB        6
`define MODE_LSB        4
`define MODE_RST        3'h0
`define DLY_RST         3'h0

// ----------------------------------------------------------------
// conversion modes
// ----------------------------------------------------------------
`define MODE_CONT       3'h0
`define MODE_SINGLE     3'h1
`define MODE_STBY       3'h2
`define MODE_PDN        3'h3

// ----------------------------------------------------------------
// settle delay, in units of one delay step
// ----------------------------------------------------------------
`define DLY_U0          8'h00
`define DLY_U1          8'h01
`define DLY_U2          8'h04
`define DLY_U3          8'h19
`define DLY_U4          8'h32
`define DLY_U5          8'h64
`define DLY_U6          8'h7d
`define DLY_U7          8'hfa

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   50
`define DLY_UNIT_NS     8000
// one 8000 ns delay unit at a 50 ns clock
`define DLY_UNIT_CYC    16'h00a0

`endif

/* hw/settle_timer.v */
`timescale 1ns/1ns
`include "adc_mode_map.vh"

// counts a number of delay units, each unit_cyc clocks long
module settle_timer #(
   parameter [15:0] UNIT_CYC = `DLY_UNIT_CYC
) (
   input  wire       mclk_i,
   input  wire       rst_n_i,
   input  wire       start_i,
   input  wire [7:0] units_i,
   output wire       busy_o,
   output wire       done_o
);

   reg [7:0]  units_r;
   reg [15:0] pres_r;
   reg        busy_r;
   reg        done_r;

   // restart wins over a running count, so a new switch never
   // inherits the tail of the old one
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         units_r <= 8'h00;
         pres_r  <= 16'h0000;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start_i) begin
            units_r <= units_i;
            pres_r  <= 16'h0000;
            busy_r  <= 1'b1;
         end else if (busy_r) begin
            if (units_r == 8'h00) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else if (pres_r == UNIT_CYC - 16'h0001) begin
               pres_r  <= 16'h0000;
               units_r <= units_r - 8'h01;
            end else begin
               pres_r <= pres_r + 16'h0001;
            end
         end
      end
   end

   assign busy_o = busy_r;
   assign done_o = done_r;

endmodule // settle_timer

/* hw/adc_mode_ctrl.v */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "adc_mode_map.vh"

module adc_mode_ctrl #(
   parameter [15:0] UNIT_CYC = `DLY_UNIT_CYC
) (
   input  wire        mclk_i,
   input  wire        nrst_i,
   input  wire [3:0]  addr_i,
   input  wire [15:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output wire [15:0] rdata_o,
   input  wire [3:0]  chan_en_i,
   input  wire        mains_rej_i,
   input  wire        conv_done_i,
   input  wire        spi_reset_i,
   output wire        filter_rst_o,
   output wire        rdy_clr_o,
   output wire        conv_run_o,
   output wire        settle_o,
   output wire [1:0]  chan_o,
   output wire        power_down_o
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   // binary codes, also read back in the status word
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_START  = 3'h1;
   localparam [2:0] ST_SETTLE = 3'h2;
   localparam [2:0] ST_CONV   = 3'h3;
   localparam [2:0] ST_PDN    = 3'h4;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   // release is synchronised so no flop leaves reset a cycle
   // ahead of its neighbours
   reg        rst_s1_r;
   reg        rst_n_r;

   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // settle length of each delay code, in delay units
   function [7:0] dly_units;
      input [2:0] code;
      begin
         case (code)
            3'h0:    dly_units = `DLY_U0;
            3'h1:    dly_units = `DLY_U1;
            3'h2:    dly_units = `DLY_U2;
            3'h3:    dly_units = `DLY_U3;
            3'h4:    dly_units = `DLY_U4;
            3'h5:    dly_units = `DLY_U5;
            3'h6:    dly_units = `DLY_U6;
            default: dly_units = `DLY_U7;
         endcase
      end
   endfunction

   // lowest enabled channel
   function [1:0] first_chan;
      input [3:0] en;
      begin
         if (en[0])
            first_chan = 2'h0;
         else if (en[1])
            first_chan = 2'h1;
         else if (en[2])
            first_chan = 2'h2;
         else
            first_chan = 2'h3;
      end
   endfunction

   // is any channel above cur enabled
   function more_above;
      input [1:0] cur;
      input [3:0] en;
      begin
         case (cur)
            2'h0:    more_above = |en[3:1];
            2'h1:    more_above = |en[3:2];
            2'h2:    more_above = en[3];
            default: more_above = 1'b0;
         endcase
      end
   endfunction

   // next enabled channel above cur, or wrap to the lowest
   function [1:0] next_chan;
      input [1:0] cur;
      input [3:0] en;
      begin
         if (cur == 2'h0 && en[1])
            next_chan = 2'h1;
         else if (cur <= 2'h1 && en[2])
            next_chan = 2'h2;
         else if (cur <= 2'h2 && en[3])
            next_chan = 2'h3;
         else
            next_chan = first_chan(en);
      end
   endfunction

   // ----------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------
   reg [2:0]  mode_r;
   reg [2:0]  dly_r;
   reg [2:0]  state_r;
   reg [1:0]  chan_r;
   reg        filt_rst_r;
   reg        rdy_clr_r;
   reg        tmr_start_r;
   reg [7:0]  tmr_units_r;
   reg [15:0] rdata_r;

   wire       tmr_done;
   wire       tmr_busy;
   wire       wr_mode;
   wire [2:0] w_mode;
   wire [2:0] w_dly;
   wire       pdn_ok;
   wire       w_ok;
   wire [7:0] sw_units;

   assign wr_mode = wr_i && (addr_i == `MODE_ADDR);
   assign w_mode  = wdata_i[`MODE_MSB:`MODE_LSB];
   assign w_dly   = wdata_i[`DLY_MSB:`DLY_LSB];
   assign pdn_ok  = (mode_r == `MODE_STBY);
   // writes while powered down, and a power-down asked for from any
   // mode but standby, are dropped whole
   assign w_ok    = wr_mode && (state_r != ST_PDN) &&
                    ((w_mode != `MODE_PDN) || pdn_ok);
   // delay has no meaning under mains rejection, so it is bypassed
   assign sw_units = mains_rej_i ? 8'h00 : dly_units(dly_r);

   always @(posedge mclk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r      <= `MODE_RST;
         dly_r       <= `DLY_RST;
         state_r     <= ST_START;
         chan_r      <= 2'h0;
         filt_rst_r  <= 1'b0;
         rdy_clr_r   <= 1'b0;
         tmr_start_r <= 1'b0;
         tmr_units_r <= 8'h00;
      end else begin
         filt_rst_r  <= 1'b0;
         rdy_clr_r   <= 1'b0;
         tmr_start_r <= 1'b0;
         if (spi_reset_i) begin
            // interface reset restores defaults and, besides the nrst_i
            // reset, is the only way out of power-down
            mode_r  <= `MODE_RST;
            dly_r   <= `DLY_RST;
            state_r <= ST_START;
            chan_r  <= 2'h0;
         end else if (w_ok) begin
            mode_r     <= w_mode;
            dly_r      <= w_dly;
            filt_rst_r <= 1'b1;
            rdy_clr_r  <= 1'b1;
            if (w_mode == `MODE_PDN) begin
               // contents are lost on the way down
               dly_r   <= `DLY_RST;
               state_r <= ST_PDN;
            end else begin
               state_r <= ST_START;
            end
         end else begin
            case (state_r)
               ST_IDLE: begin
                  state_r <= ST_IDLE;
               end
               ST_START: begin
                  if ((mode_r == `MODE_CONT || mode_r == `MODE_SINGLE)
                      && (chan_en_i != 4'h0)) begin
                     chan_r      <= first_chan(chan_en_i);
                     tmr_units_r <= sw_units;
                     tmr_start_r <= 1'b1;
                     state_r     <= ST_SETTLE;
                  end else begin
                     // standby and reserved codes: nothing to do
                     state_r <= ST_IDLE;
                  end
               end
               ST_SETTLE: begin
                  // done is registered, so the run opens one cycle later
                  if (tmr_done)
                     state_r <= ST_CONV;
               end
               ST_CONV: begin
                  if (conv_done_i) begin
                     // single mode stops after the top enabled channel
                     if (mode_r == `MODE_SINGLE &&
                         !more_above(chan_r, chan_en_i)) begin
                        mode_r  <= `MODE_STBY;
                        state_r <= ST_IDLE;
                     end else if (chan_en_i == 4'h0) begin
                        state_r <= ST_IDLE;
                     end else if (next_chan(chan_r, chan_en_i)
                                  != chan_r) begin
                        chan_r      <= next_chan(chan_r, chan_en_i);
                        tmr_units_r <= sw_units;
                        tmr_start_r <= 1'b1;
                        state_r     <= ST_SETTLE;
                     end
                     // one channel only: no switch, keep converting
                  end
               end
               ST_PDN: begin
                  state_r <= ST_PDN;
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // settling delay
   // ----------------------------------------------------------------
   // the first channel after a start is delayed as well
   settle_timer #(
      .UNIT_CYC (UNIT_CYC)
   ) u_settle (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_r),
      .start_i (tmr_start_r),
      .units_i (tmr_units_r),
      .busy_o  (tmr_busy),
      .done_o  (tmr_done)
   );

   // ----------------------------------------------------------------
   // read words
   // ----------------------------------------------------------------
   wire [15:0] mode_word;
   wire [15:0] stat_word;

   // reserved bits read back as zero
   assign mode_word = {5'h00, dly_r, 1'b0, mode_r, 4'h0};
   assign stat_word = {9'h000, tmr_busy, (state_r == ST_PDN), chan_r,
                       state_r};

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   // rdata is zero outside its one valid cycle
   always @(posedge mclk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            `MODE_ADDR: rdata_r <= mode_word;
            `STAT_ADDR: rdata_r <= stat_word;
            default:    rdata_r <= 16'h0000;
         endcase
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata_o      = rdata_r;
   assign filter_rst_o = filt_rst_r;
   assign rdy_clr_o    = rdy_clr_r;
   assign conv_run_o   = (state_r == ST_CONV);
   assign settle_o     = (state_r == ST_SETTLE);
   assign chan_o       = chan_r;
   assign power_down_o = (state_r == ST_PDN);

endmodule // adc_mode_ctrl

/* sim/conv_model.sv */
`timescale 1ns/1ns
// converter stand-in: finishes a conversion lat_i+1 clocks into a run
module conv_model (
   input  wire logic       mclk_i,
   input  wire logic       run_i,
   input  wire logic [3:0] lat_i,
   output logic            done_o
);
   logic [3:0] cnt_r = 4'h0;
   initial done_o = 1'b0;
   always @(posedge mclk_i) begin
      done_o <= 1'b0;
      if (!run_i) begin
         cnt_r <= 4'h0;
      end else if (cnt_r == lat_i) begin
         cnt_r  <= 4'h0;
         done_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule // conv_model

/* sim/adc_mode_ctrl_asserts.sv */
`timescale 1ns/1ns
module adc_mode_ctrl_chk #(
   parameter [15:0] UNIT_CYC = 16'd2
) (
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic [3:0]  chan_en_i,
   input wire logic        mains_rej_i,
   input wire logic        conv_done_i,
   input wire logic        spi_reset_i,
   input wire logic        filter_rst_o,
   input wire logic        rdy_clr_o,
   input wire logic        conv_run_o,
   input wire logic        settle_o,
   input wire logic [1:0]  chan_o,
   input wire logic        power_down_o
);
   logic [2:0]  wmode_r;
   logic [2:0]  dly_r;
   logic [15:0] cnt_r;
   function automatic logic [15:0] units(input logic [2:0] c);
      case (c)
         3'h0:    units = 16'h0000;
         3'h1:    units = 16'h0001;
         3'h2:    units = 16'h0004;
         3'h3:    units = 16'h0019;
         3'h4:    units = 16'h0032;
         3'h5:    units = 16'h0064;
         3'h6:    units = 16'h007d;
         default: units = 16'h00fa;
      endcase
   endfunction
   // last accepted mode write other than power-down, so refusals can be judged from the ports
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wmode_r <= 3'h0;
         dly_r   <= 3'h0;
         cnt_r   <= 16'h0;
      end else begin
         if (spi_reset_i) begin
            wmode_r <= 3'h0;
            dly_r   <= 3'h0;
         end else if (wr_i && addr_i == 4'h1 && !power_down_o &&
                      wdata_i[6:4] != 3'h3) begin
            wmode_r <= wdata_i[6:4];
            dly_r   <= wdata_i[10:8];
         end
         cnt_r <= settle_o ? cnt_r + 16'h1 : 16'h0;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence mode_wr_s;
      wr_i && addr_i == 4'h1 && !spi_reset_i && !power_down_o &&
      wdata_i[6:4] != 3'h3;
   endsequence
   sequence pdn_req_s;
      wr_i && addr_i == 4'h1 && !spi_reset_i && wdata_i[6:4] == 3'h3;
   endsequence
   chk_write_pulse: assert property (
      mode_wr_s |=> filter_rst_o && rdy_clr_o)
      else $error("mode write gave no filter reset");
   chk_fresh_start: assert property (mode_wr_s |=> !conv_run_o)
      else $error("conversion kept running over a mode write");
   chk_pdn_refuse: assert property (
      pdn_req_s ##0 (wmode_r == 3'h0 && !power_down_o) |=>
      !filter_rst_o ##1 !power_down_o)
      else $error("power down taken outside standby");
   chk_pdn_hold: assert property (
      power_down_o && !spi_reset_i |=> power_down_o)
      else $error("power down left without interface reset");
   chk_pdn_exit: assert property (
      spi_reset_i |=> (!power_down_o)[*2])
      else $error("interface reset did not leave power down");
   chk_pdn_quiet: assert property (
      power_down_o |-> !conv_run_o && !settle_o)
      else $error("converter active in power down");
   chk_settle_excl: assert property (!(settle_o && conv_run_o))
      else $error("conversion during settling");
   chk_settle_first: assert property (
      $rose(conv_run_o) && !mains_rej_i |-> $past(settle_o))
      else $error("conversion began without settling");
   chk_settle_len: assert property (
      $fell(settle_o) && conv_run_o && !mains_rej_i |->
      cnt_r == units(dly_r) * UNIT_CYC + 16'h0003)
      else $error("settling length wrong");
   chk_chan_valid: assert property (conv_run_o |-> chan_en_i[chan_o])
      else $error("converting a disabled channel");
   chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside its cycle");
endmodule // adc_mode_ctrl_chk
bind adc_mode_ctrl adc_mode_ctrl_chk #(.UNIT_CYC(UNIT_CYC)) u_chk (
   .mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chan_en_i,
   .mains_rej_i, .conv_done_i, .spi_reset_i, .filter_rst_o, .rdy_clr_o,
   .conv_run_o, .settle_o, .chan_o, .power_down_o);

/* sim/tb_adc_mode_ctrl.sv */
`timescale 1ns/1ns
module tb_adc_mode_ctrl;
   logic        mclk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic        mains_rej_i = 1'b0, spi_reset_i = 1'b0;
   logic [3:0]  addr_i = 4'h0, chan_en_i = 4'h1, lat = 4'h2;
   logic [15:0] wdata_i = 16'h0000;
   wire  [15:0] rdata_o;
   wire  [1:0]  chan_o;
   wire         conv_done_i, filter_rst_o, rdy_clr_o;
   wire         conv_run_o, settle_o, power_down_o;
   integer      errors = 0, n_checks = 0, seed = 32'hf359, n, k, c;
   int          q[$];
   int          units_t[8] = '{0, 1, 4, 25, 50, 100, 125, 250};
   localparam int UC = 2;
   always #25 mclk_i = ~mclk_i;
   adc_mode_ctrl #(.UNIT_CYC(16'd2)) u_adc_mode_ctrl (
      .mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .chan_en_i, .mains_rej_i, .conv_done_i, .spi_reset_i, .filter_rst_o,
      .rdy_clr_o, .conv_run_o, .settle_o, .chan_o, .power_down_o);
   conv_model u_conv_model (.mclk_i, .run_i(conv_run_o), .lat_i(lat),
      .done_o(conv_done_i));
   task check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // reserved bits 15:11 and 7 always go out as zero; bits 3:0 pass through unmasked
   task wr(input logic [15:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= 4'h1;
      wdata_i <= d & 16'h077f;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, exp);
   endtask
   task wait_run(input logic lvl);
      integer i;
      i = 0;
      while (conv_run_o !== lvl && i < 3000) begin
         @(posedge mclk_i);
         #1;
         i++;
      end
      check({15'h0, conv_run_o}, {15'h0, lvl});
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rd(4'h1, 16'h0000);
      rd(4'h7, 16'h0000);
      for (k = 0; k < 8; k++) begin
         wr({5'h0, k[2:0], 8'h00});
         check({14'h0, filter_rst_o, rdy_clr_o}, 16'h0003);
         n = 0;
         repeat (600) begin
            @(posedge mclk_i);
            #1;
            if (settle_o) n++;
         end
         check(16'(n), 16'(units_t[k] * UC + 3));
         check({15'h0, conv_run_o}, 16'h0001);
      end
      @(posedge mclk_i);
      chan_en_i <= 4'($random(seed)) | 4'h5;
      lat <= 4'h2 + (4'($random(seed)) & 4'h7);
      wr(16'h0100);
      c = 0;
      for (n = 0; n < 6; n++) begin
         q.push_back(c);
         c = (c + 1) % 4;
         while (!chan_en_i[c]) c = (c + 1) % 4;
      end
      for (k = 0; k < 6; k++) begin
         wait_run(1'b1);
         check({14'h0, chan_o}, 16'(q.pop_front()));
         wait_run(1'b0);
      end
      wr(16'h0020);
      @(posedge mclk_i);
      chan_en_i <= 4'h5;
      wr(16'h0010);
      for (k = 0; k < 4; k += 2) begin
         wait_run(1'b1);
         check({14'h0, chan_o}, 16'(k));
         wait_run(1'b0);
      end
      repeat (3) @(posedge mclk_i);
      rd(4'h1, 16'h0020);
      rd(4'h3, 16'h0010);
      wr(16'h0000);
      wr(16'h0030);
      check({15'h0, filter_rst_o}, 16'h0000);
      rd(4'h1, 16'h0000);
      wr(16'h0020);
      wr(16'h0030);
      repeat (2) @(posedge mclk_i);
      #1;
      check({14'h0, power_down_o, conv_run_o}, 16'h0002);
      wr(16'h0000);
      check({14'h0, power_down_o, filter_rst_o}, 16'h0002);
      @(posedge mclk_i);
      spi_reset_i <= 1'b1;
      @(posedge mclk_i);
      spi_reset_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      check({15'h0, power_down_o}, 16'h0000);
      rd(4'h1, 16'h0000);
      // host only checks that the run opens within 4 clocks while mains rejection is on
      @(posedge mclk_i);
      mains_rej_i <= 1'b1;
      wr(16'h0700);
      repeat (4) @(posedge mclk_i);
      #1;
      check({15'h0, conv_run_o}, 16'h0001);
      test_done;
   end
   initial begin
      #(50 * 20000);
      errors++;
      test_done;
   end
endmodule // tb_adc_mode_ctrl
